/* File: mob_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - strictly ordered accesses never overlap; later waits for earlier to complete
// - ordered accesses may overlap but are issued in arrival order
// - each word of a multi-word transfer is a separate access
// - first word of a new instruction waits until all older accesses complete
// - multi-word words issue in presented ascending-address order
// - program-counter multi-loads may present words in any order
// - doubleword load or store words may come in either order
// - atomicity-split operations may present their accesses in any order
// - memory and sync barriers wait for earlier accesses; sync and instruction barriers discard prefetched instructions
// - data memory barriers never touch the instruction fetch path; sync barriers flush it
// - domain and access-type arguments are ignored; barriers act system-wide
// - first group is every access taken before the barrier
// - second group is every access taken after the barrier
// - for memory and sync barriers, no second-group access issues before all first-group accesses complete; an instruction barrier does not wait
// - peripherals see first-group accesses before any second-group access
// - accesses outside both groups keep normal ordering freedom
// - data memory barrier never stalls non-memory instructions
// - sync barrier gives all data memory barrier ordering
// - sync barrier completes only when all earlier accesses are complete
// - sync barrier also waits for context-altering control space accesses
// - instructions after a sync barrier stall until it completes
// - instruction barrier flushes so later instructions are refetched afterwards
module mob_ctrl
(
	input  wire logic                  i_core_clk,
	input  wire logic                  i_arst_n,
	input  wire logic                  i_acc_valid,
	input  wire logic [mob_pkg::ADDR_W-1:0] i_acc_addr,
	input  wire logic                  i_acc_write,
	input  wire logic                  i_acc_first,
	input  wire logic                  i_acc_any_order,
	input  wire logic                  i_acc_ctx,
	output logic                       o_acc_ready,
	input  wire logic                  i_bar_valid,
	input  wire logic [1:0]            i_bar_kind,
	input  wire logic [3:0]            i_bar_option,
	output logic                       o_bar_ready,
	output logic                       o_bar_done,
	output logic                       o_exec_stall,
	output logic                       o_prefetch_flush,
	output logic                       o_mem_valid,
	output logic [mob_pkg::ADDR_W-1:0] o_mem_addr,
	output logic                       o_mem_write,
	output logic                       o_mem_ctx,
	input  wire logic                  i_mem_accept,
	input  wire logic                  i_mem_done,
	input  wire logic                  i_mem_done_ctx
);
	import mob_pkg::*;

	mob_state_t q;
	mob_state_t n;
	logic       mem_acc;
	logic       issue;
	logic       take_acc;
	logic       take_bar;
	logic       done_ok;
	logic       sdone_ok;
	logic       drained;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [CNT_W-1:0] cnt_step(input logic [CNT_W-1:0] c,
		input logic up, input logic dn);
		logic [CNT_W-1:0] r;
		r = c;
		if (up && !dn)
		begin
			r = c + CNT_ONE;
		end
		else if (dn && !up)
		begin
			r = c - CNT_ONE;
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		n        = q;
		n.flush  = 1'b0;
		n.bdone  = 1'b0;
		mem_acc  = q.mvalid && i_mem_accept;
		done_ok  = i_mem_done && (q.cnt != CNT_ZERO);
		sdone_ok = i_mem_done && i_mem_done_ctx && (q.scnt != CNT_ZERO);
		// new instruction waits for everything older; words of one
		// instruction may overlap
		issue    = q.pend && !q.mvalid && (q.cnt != CNT_MAX)
			&& (!q.pend_first || (q.cnt == CNT_ZERO));
		// barrier only after every older access has been taken
		take_bar = i_bar_valid && q.bar_rdy && !i_acc_valid;
		take_acc = i_acc_valid && q.acc_rdy;
		drained  = !q.pend && !q.mvalid && (q.cnt == CNT_ZERO);

		if (mem_acc)
		begin
			n.mvalid = 1'b0;
		end
		n.cnt  = cnt_step(q.cnt, mem_acc, done_ok);
		n.scnt = cnt_step(q.scnt, mem_acc && q.mscs, sdone_ok);

		// words leave in the order presented; ascending or free order
		// is the pipeline's choice per instruction
		if (issue)
		begin
			n.mvalid = 1'b1;
			n.maddr  = q.pend_addr;
			n.mwr    = q.pend_wr;
			n.mfirst = q.pend_first;
			n.mscs   = q.pend_ctx;
			n.many   = q.pend_any;
			n.pend   = 1'b0;
		end
		if (take_acc)
		begin
			n.pend       = 1'b1;
			n.pend_addr  = i_acc_addr;
			n.pend_wr    = i_acc_write;
			n.pend_first = i_acc_first;
			n.pend_ctx   = i_acc_ctx;
			n.pend_any   = i_acc_any_order;
		end

		// option field deliberately unused: always full system
		case (q.st)
			MOB_IDLE:
			begin
				if (take_bar)
				begin
					case (i_bar_kind)
						MOB_BAR_SYNC:  n.st = MOB_SYNC_WAIT;
						MOB_BAR_INSTR: n.st = MOB_INSTR_WAIT;
						default:       n.st = MOB_MEM_WAIT;
					endcase
				end
			end
			MOB_MEM_WAIT:
			begin
				if (drained)
				begin
					n.st    = MOB_IDLE;
					n.bdone = 1'b1;
				end
			end
			MOB_SYNC_WAIT:
			begin
				if (drained && (q.scnt == CNT_ZERO))
				begin
					n.st    = MOB_IDLE;
					n.bdone = 1'b1;
					n.flush = 1'b1;
				end
			end
			MOB_INSTR_WAIT:
			begin
				n.st    = MOB_IDLE;
				n.bdone = 1'b1;
				n.flush = 1'b1;
			end
			default:
			begin
				n.st = MOB_IDLE;
			end
		endcase

		// accesses outside a barrier window flow freely
		n.acc_rdy = (n.st == MOB_IDLE) && !n.pend;
		n.bar_rdy = (n.st == MOB_IDLE) && !n.pend;
		// memory barrier leaves execution running
		n.stall   = (n.st == MOB_SYNC_WAIT) || (n.st == MOB_INSTR_WAIT);
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			q <= MOB_RESET;
		end
		else
		begin
			q <= n;
		end
	end

	// ----------------------------------------------------------------
	// outputs; fetch path has no input here at all
	// ----------------------------------------------------------------
	assign o_acc_ready      = q.acc_rdy;
	assign o_bar_ready      = q.bar_rdy;
	assign o_bar_done       = q.bdone;
	assign o_exec_stall     = q.stall;
	assign o_prefetch_flush = q.flush;
	assign o_mem_valid      = q.mvalid;
	assign o_mem_addr       = q.maddr;
	assign o_mem_write      = q.mwr;
	assign o_mem_ctx        = q.mscs;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic [ADDR_W-1:0] last_addr_q;
	mob_st_t           prev_st_q;
	always_ff @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			last_addr_q <= 32'h0000_0000;
			prev_st_q   <= MOB_IDLE;
		end
		else
		begin
			prev_st_q <= q.st;
			if (mem_acc)
			begin
				last_addr_q <= q.maddr;
			end
		end
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n);

	property p_strict_first;
		(issue && q.pend_first) |-> (q.cnt == CNT_ZERO) ##1 (o_mem_valid && q.mfirst);
	endproperty
	a_strict_first: assert property (p_strict_first) else $error("new instruction overlapped");

	property p_hold_req;
		(o_mem_valid && !i_mem_accept) |=> (o_mem_valid && $stable(o_mem_addr));
	endproperty
	a_hold_req: assert property (p_hold_req) else $error("request dropped before accept");

	property p_ascend;
		(mem_acc && !q.mfirst && !q.many) |-> (q.maddr > last_addr_q);
	endproperty
	a_ascend: assert property (p_ascend) else $error("multi-word order broken");

	property p_group_block;
		(q.st != MOB_IDLE) |-> (!o_acc_ready && !o_bar_ready);
	endproperty
	a_group_block: assert property (p_group_block) else $error("access taken in barrier");

	property p_mem_nostall;
		(take_bar && (i_bar_kind == MOB_BAR_MEM)) |=> !o_exec_stall throughout (q.st == MOB_MEM_WAIT);
	endproperty
	a_mem_nostall: assert property (p_mem_nostall) else $error("memory barrier stalled execution");

	property p_sync_stall;
		(take_bar && (i_bar_kind == MOB_BAR_SYNC)) |=> o_exec_stall;
	endproperty
	a_sync_stall: assert property (p_sync_stall) else $error("sync barrier did not stall");

	property p_sync_done;
		(o_bar_done && (prev_st_q == MOB_SYNC_WAIT))
			|-> ($past(q.cnt) == CNT_ZERO) && ($past(q.scnt) == CNT_ZERO) && o_prefetch_flush;
	endproperty
	a_sync_done: assert property (p_sync_done) else $error("sync barrier ended early");

	property p_instr_flush;
		(take_bar && (i_bar_kind == MOB_BAR_INSTR)) |=> o_exec_stall ##1 (o_prefetch_flush && o_bar_done);
	endproperty
	a_instr_flush: assert property (p_instr_flush) else $error("instruction barrier flush missing");

	property p_mem_done;
		(o_bar_done && (prev_st_q == MOB_MEM_WAIT)) |-> ($past(q.cnt) == CNT_ZERO) && !o_prefetch_flush;
	endproperty
	a_mem_done: assert property (p_mem_done) else $error("memory barrier ended early");

	property p_flush_pair;
		o_prefetch_flush |-> o_bar_done;
	endproperty
	a_flush_pair: assert property (p_flush_pair) else $error("flush without barrier end");

	property p_ctx_wait;
		((q.st == MOB_SYNC_WAIT) && (q.scnt != CNT_ZERO)) |=> !o_bar_done;
	endproperty
	a_ctx_wait: assert property (p_ctx_wait) else $error("sync barrier left context access");

	property p_hold_fields;
		(o_mem_valid && !i_mem_accept) |=> ($stable(o_mem_write) && $stable(o_mem_ctx));
	endproperty
	a_hold_fields: assert property (p_hold_fields) else $error("request fields moved");

	property p_mem_wait;
		((q.st == MOB_MEM_WAIT) && (q.cnt != CNT_ZERO)) |=> !o_bar_done;
	endproperty
	a_mem_wait: assert property (p_mem_wait) else $error("memory barrier passed open access");

	property p_stall_release;
		o_bar_done |-> !o_exec_stall;
	endproperty
	a_stall_release: assert property (p_stall_release) else $error("stall held past barrier");

endmodule // mob_ctrl
`default_nettype wire

/* File: mob_pkg.sv */
package mob_pkg;

	// ----------------------------------------------------------------
	// sizes and counts
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W  = 32;
	localparam int unsigned CNT_W   = 4;
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
	localparam logic [CNT_W-1:0] CNT_MAX  = 4'hf;

	// ----------------------------------------------------------------
	// barrier kinds presented by the pipeline
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MOB_BAR_MEM   = 2'h0,
		MOB_BAR_SYNC  = 2'h1,
		MOB_BAR_INSTR = 2'h2
	} mob_bar_t;

	// ----------------------------------------------------------------
	// control states, one-hot
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		MOB_IDLE       = 4'h1,
		MOB_MEM_WAIT   = 4'h2,
		MOB_SYNC_WAIT  = 4'h4,
		MOB_INSTR_WAIT = 4'h8
	} mob_st_t;

	// ----------------------------------------------------------------
	// whole state of the controller
	// ----------------------------------------------------------------
	typedef struct packed {
		mob_st_t           st;
		logic              pend;
		logic [ADDR_W-1:0] pend_addr;
		logic              pend_wr;
		logic              pend_first;
		logic              pend_ctx;
		logic              pend_any;
		logic              mvalid;
		logic [ADDR_W-1:0] maddr;
		logic              mwr;
		logic              mfirst;
		logic              mscs;
		logic              many;
		logic [CNT_W-1:0]  cnt;
		logic [CNT_W-1:0]  scnt;
		logic              acc_rdy;
		logic              bar_rdy;
		logic              stall;
		logic              flush;
		logic              bdone;
	} mob_state_t;

	localparam mob_state_t MOB_RESET = '{
		st: MOB_IDLE, pend: 1'b0, pend_addr: 32'h0000_0000, pend_wr: 1'b0,
		pend_first: 1'b0, pend_ctx: 1'b0, pend_any: 1'b0, mvalid: 1'b0,
		maddr: 32'h0000_0000, mwr: 1'b0, mfirst: 1'b0, mscs: 1'b0, many: 1'b0,
		cnt: 4'h0, scnt: 4'h0, acc_rdy: 1'b1, bar_rdy: 1'b1, stall: 1'b0,
		flush: 1'b0, bdone: 1'b0};

endpackage

/* File: mob_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mob_mem_model
(
	input  wire logic       i_clk,
	input  wire logic       i_arst_n,
	input  wire logic       i_hold,
	input  wire logic [3:0] i_acc_lat,
	input  wire logic [3:0] i_done_lat,
	input  wire logic       i_valid,
	input  wire logic       i_ctx,
	output logic            o_accept,
	output logic            o_done,
	output logic            o_done_ctx
);
	logic       q [$];
	logic [3:0] wa;
	logic [3:0] wd;
	logic       sc;

	always @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			q.delete();
			wa = 4'h0;
			wd = 4'h0;
			o_accept <= 1'b0;
			o_done <= 1'b0;
			o_done_ctx <= 1'b0;
		end
		else
		begin
			o_done <= 1'b0;
			o_done_ctx <= 1'b0;
			if (o_accept && i_valid)
			begin
				o_accept <= 1'b0;
				q.push_back(sc);
			end
			else if (i_valid && wa >= i_acc_lat)
			begin
				o_accept <= 1'b1;
				sc = i_ctx;
				wa = 4'h0;
			end
			else if (i_valid)
				wa = wa + 4'h1;
			// one completion per accepted access, held back on request
			if (q.size() != 0 && !i_hold)
			begin
				if (wd >= i_done_lat)
				begin
					o_done <= 1'b1;
					o_done_ctx <= q.pop_front();
					wd = 4'h0;
				end
				else
					wd = wd + 4'h1;
			end
		end
	end
endmodule // mob_mem_model
`default_nettype wire

/* File: tb_memory_order_barrier_control.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_memory_order_barrier_control;
	import mob_pkg::*;
	logic        clk = 1'b0, rst_n = 1'b1, av = 1'b0, aw = 1'b0, af = 1'b0;
	logic        ao = 1'b0, as = 1'b0, bv = 1'b0, hold = 1'b0;
	logic [31:0] aa = 32'h0;
	logic [1:0]  bk = 2'h0;
	logic [3:0]  bo = 4'h0;
	logic        ar, br, bd, st, fl, mv, mw, ms, acc, dn, ds;
	logic [31:0] ma;
	int          num_errors, checks, cycles, outst;
	logic [31:0] iss [$];
	logic        fq [$];
	logic        sq [$];

	always #20 clk = ~clk;

	mob_ctrl mob_ctrl_inst (.i_core_clk(clk), .i_arst_n(rst_n), .i_acc_valid(av),
		.i_acc_addr(aa), .i_acc_write(aw), .i_acc_first(af), .i_acc_any_order(ao),
		.i_acc_ctx(as), .o_acc_ready(ar), .i_bar_valid(bv), .i_bar_kind(bk),
		.i_bar_option(bo), .o_bar_ready(br), .o_bar_done(bd), .o_exec_stall(st),
		.o_prefetch_flush(fl), .o_mem_valid(mv), .o_mem_addr(ma), .o_mem_write(mw),
		.o_mem_ctx(ms), .i_mem_accept(acc), .i_mem_done(dn), .i_mem_done_ctx(ds));
	mob_mem_model mob_mem_model_inst (.i_clk(clk), .i_arst_n(rst_n), .i_hold(hold),
		.i_acc_lat(4'h2), .i_done_lat(4'h3), .i_valid(mv), .i_ctx(ms),
		.o_accept(acc), .o_done(dn), .o_done_ctx(ds));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// issue monitor: a new instruction's first word finds nothing outstanding
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			num_errors++;
			conclude();
		end
		if (mv && acc)
		begin
			if (fq.pop_front())
				check(outst, 0);
			check(ms, sq.pop_front());
			iss.push_back(ma | {31'h0, mw});
		end
		if (rst_n)
			outst = outst + int'(mv && acc) - int'(dn);
	end

	task automatic send(input logic [31:0] a, input logic w, f, o, s);
		int n;
		@(negedge clk);
		av = 1'b1;
		aa = a;
		aw = w;
		af = f;
		ao = o;
		as = s;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (!ar && n < 50);
		fq.push_back(f);
		sq.push_back(s);
		@(negedge clk);
		av = 1'b0;
		aa = ~a;
	endtask

	task automatic drain;
		int n = 0;
		while ((outst != 0 || mv || !ar) && n < 100)
		begin
			@(negedge clk);
			n++;
		end
		check(outst, 0);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		check({ar, br}, 2'h3);
		check({bd, st, fl, mv, mw, ms}, 6'h0);
		check(ma, 32'h0);
		$display("t_reset done");
	endtask

	task automatic t_order;
		logic [31:0] e [6] = '{32'h100, 32'h104, 32'h108, 32'h20d, 32'h209, 32'h301};
		iss.delete();
		send(32'h100, 1'b0, 1'b1, 1'b0, 1'b0);
		send(32'h104, 1'b0, 1'b0, 1'b0, 1'b0);
		send(32'h108, 1'b0, 1'b0, 1'b0, 1'b0);
		send(32'h20c, 1'b1, 1'b1, 1'b1, 1'b0);
		send(32'h208, 1'b1, 1'b0, 1'b1, 1'b0);
		send(32'h300, 1'b1, 1'b1, 1'b0, 1'b0);
		drain();
		check(iss.size(), 6);
		foreach (e[i])
			check(iss[i], e[i]);
		$display("t_order done");
	endtask

	task automatic t_bar(input logic [1:0] k, input logic [3:0] o);
		logic ibar, sbar;
		int n;
		ibar = (k == 2'h2);
		sbar = (k == 2'h1) || ibar;
		hold = 1'b1;
		send(32'h400, 1'b1, 1'b1, 1'b0, 1'b1);
		n = 0;
		while (outst == 0 && n < 20)
		begin
			@(negedge clk);
			n++;
		end
		bk = k;
		bo = o;
		bv = 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (!br && n < 20);
		@(negedge clk);
		bv = 1'b0;
		check(st, sbar);
		@(negedge clk);
		check({bd, fl}, {ibar, ibar});
		repeat (3)
		begin
			@(negedge clk);
			check(bd, 1'b0);
		end
		hold = 1'b0;
		if (!ibar)
		begin
			n = 0;
			while (!bd && n < 30)
			begin
				@(negedge clk);
				n++;
			end
			check({bd, fl, st}, {1'b1, sbar, 1'b0});
			check(outst, 0);
		end
		drain();
		$display("t_bar %0d done", k);
	endtask

	initial
	begin
		#1 rst_n = 1'b0;
		repeat (2) @(negedge clk);
		t_reset();
		rst_n = 1'b1;
		t_order();
		for (int k = 0; k < 4; k++)
			t_bar(k[1:0], 4'hf - k[3:0]);
		conclude();
	end
endmodule // tb_memory_order_barrier_control
`default_nettype wire
